// ---- src/wdr_pkg.sv ----
/*
  types for the watchdog and reset-flag block.
  assumes: wdr_regs.svh is on the include path.
*/
`include "wdr_regs.svh"

package wdr_pkg;

  typedef struct packed
  {
    logic                  read;
    logic                  write;
    logic [`WDR_AW-1:0]    address;
    logic [`WDR_DW-1:0]    writedata;
  } wdr_bus_req_t;

  typedef struct packed
  {
    logic                  waitrequest;
    logic [`WDR_DW-1:0]    readdata;
  } wdr_bus_rsp_t;

  typedef struct packed
  {
    logic                  por;
    logic                  ext;
    logic                  pfail;
  } wdr_rst_cause_t;

  typedef enum logic [1:0]
  {
    WDR_RUN,
    WDR_WAIT_RST,
    WDR_FIRE
  } wdr_state_t;

  typedef enum logic [1:0]
  {
    WDR_KEY_IDLE,
    WDR_KEY_HALF,
    WDR_KEY_OPEN
  } wdr_key_t;

endpackage

// ---- src/wdr_regs.svh ----
/*
  register offsets, field positions and timing counts
  of the watchdog and reset-flag block.
  assumes: included by bare name from the package, the checker and the bench.
*/
`ifndef WDR_REGS_SVH
`define WDR_REGS_SVH

// word offsets on the register bus (byte address = 4 * index)
`define WDR_IDX_WDCTL      8'hD8
`define WDR_IDX_TAKEY      8'hC7
`define WDR_IDX_IRQEN      8'hE8
`define WDR_IDX_ISTAT      8'hE9
`define WDR_IDX_IMASK      8'hEA

// watchdog_control fields
`define WDR_B_BAUD2        7
`define WDR_B_POR          6
`define WDR_B_IRQF         3
`define WDR_B_RSTF         2
`define WDR_B_RSTEN        1
`define WDR_B_RESTART      0

// irq enable register field
`define WDR_B_IRQEN        4

// interrupt status / mask fields
`define WDR_B_EV_TIMEOUT   0
`define WDR_B_EV_WDRESET   1
`define WDR_EV_W           2

// timed access keys and window
`define WDR_KEY_FIRST      8'hAA
`define WDR_KEY_SECOND     8'h55
`define WDR_CLK_PER_MC     4
`define WDR_TA_MC          3
`define WDR_TA_CYC         (`WDR_TA_MC * `WDR_CLK_PER_MC)

// reset delay after time-out, in clocks
`define WDR_RST_DELAY      10'd512

// default time-out interval in clocks
`define WDR_TIMEOUT_DFLT   131072

// bus address width and data width
`define WDR_AW             10
`define WDR_DW             32

`endif

// ---- src/wdr_watchdog.sv ----
/*
  watchdog control and reset-cause flags, reached over avalon-mm.
  assumes: rst_i is the external reset pin; power-on and power-fail
  causes arrive as one-cycle pulses; the chip reset controller feeds
  wdog_reset_o back as a watchdog-caused reset through wd_rst_i.
*/
// Added by the designer: register access over Avalon-MM.
// What this block does
// - a power-up sets the power-on flag, which only a software write clears.
// - with the watchdog interrupt enabled, a time-out sets the irq flag.
// - with the interrupt disabled, a time-out still sets the irq flag.
// - a watchdog reset sets the reset flag until software, power-on or power-fail clears it.
// - with reset enable clear, watchdog activity leaves the reset flag alone.
// - setting the reset enable arms the watchdog system reset.
// - writing one to restart reloads the counter and the bit clears itself.
// - a time-out raises the interrupt if enabled and, if armed, a reset 512 clocks later.
// - an external reset loads the control register with pattern 0x000xx0b.
// - the reset flag is 1 after watchdog reset, 0 after power resets, kept on external.
// - power-on sets the power-on flag and clears reset enable; others keep it.
// - all bits read freely; power-on, enable, irq flag and restart need an open window.
// - writing AA then 55 to the key register opens a three machine-cycle window.
// - a separate irq enable bit gates whether a time-out raises the interrupt.
`timescale 1ns/100ps

module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter int TIMEOUT_CYC = `WDR_TIMEOUT_DFLT
)
(
  // clock and resets
  input  wire logic            sys_clk_i,
  input  wire logic            rst_i,
  input  wire wdr_rst_cause_t  cause_i,
  input  wire logic            wd_rst_i,
  // register bus
  input  wire logic [9:0]      avs_address_i,
  input  wire logic            avs_read_i,
  input  wire logic            avs_write_i,
  input  wire logic [31:0]     avs_writedata_i,
  output logic      [31:0]     avs_readdata_o,
  output logic                 avs_waitrequest_o,
  // events
  output logic                 wdog_irq_o,
  output logic                 wdog_reset_o,
  output logic                 irq_o
);

  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a[9:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // control register bits and internal state
  logic        baud2_reg;
  logic        por_reg;
  logic        irqf_reg;
  logic        rstf_reg;
  logic        rsten_reg;
  logic        restart_reg;
  logic        irqen_reg;
  logic [`WDR_EV_W-1:0] istat_reg;
  logic [`WDR_EV_W-1:0] imask_reg;
  logic [31:0] rdata_reg;
  logic        ack_reg;
  wdr_key_t    key_reg;
  logic [3:0]  ta_cnt_reg;
  wdr_state_t  st_reg;
  logic [31:0] wd_cnt_reg;
  logic [9:0]  dly_reg;
  logic        fire_reg;

  // bus decode: one wait state, answer at the second edge
  wire         req       = avs_read_i | avs_write_i;
  wire         take      = req & ~ack_reg;
  wire         wr        = avs_write_i & take;
  wire         rd        = avs_read_i & take;
  wire [7:0]   wd        = avs_writedata_i[7:0];
  wire         sel_ctl   = hit(avs_address_i, `WDR_IDX_WDCTL);
  wire         sel_key   = hit(avs_address_i, `WDR_IDX_TAKEY);
  wire         sel_ien   = hit(avs_address_i, `WDR_IDX_IRQEN);
  wire         sel_ist   = hit(avs_address_i, `WDR_IDX_ISTAT);
  wire         sel_msk   = hit(avs_address_i, `WDR_IDX_IMASK);
  wire         wr_ctl    = wr & sel_ctl;
  wire         ta_open   = (key_reg == WDR_KEY_OPEN);
  wire         wr_prot   = wr_ctl & ta_open;
  wire         rd_ist    = rd & sel_ist;

  // watchdog counter and time-out
  wire         restart   = wr_prot & wd[`WDR_B_RESTART];
  wire         timeout   = (st_reg == WDR_RUN) &&
                           (wd_cnt_reg == 32'(TIMEOUT_CYC - 1));
  wire         pwr_rst   = cause_i.por | cause_i.pfail;

  wire [7:0]   ctl_view  = {baud2_reg, por_reg, 2'b00, irqf_reg,
                            rstf_reg, rsten_reg, restart_reg};
  wire [`WDR_EV_W-1:0] ev;
  assign ev[`WDR_B_EV_TIMEOUT] = timeout;
  assign ev[`WDR_B_EV_WDRESET] = wd_rst_i & rsten_reg;

  wire [31:0]  rd_mux =
      sel_ctl ? {24'h000000, ctl_view} :
      sel_key ? 32'h00000000 :
      sel_ien ? {24'h000000, 3'b111, irqen_reg, 4'h0} :
      sel_ist ? {30'h00000000, istat_reg} :
      sel_msk ? {30'h00000000, imask_reg} :
                32'h00000000;

  assign avs_waitrequest_o = req & ~ack_reg;
  assign avs_readdata_o    = rdata_reg;
  assign wdog_irq_o        = irqf_reg & irqen_reg;
  assign wdog_reset_o      = fire_reg;
  assign irq_o             = |(istat_reg & imask_reg);

  // bus handshake
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= take;
      if (rd)
        rdata_reg <= rd_mux;
    end
  end

  // timed access key sequence
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      key_reg    <= WDR_KEY_IDLE;
      ta_cnt_reg <= 4'h0;
    end
    else
    begin
      case (key_reg)
        WDR_KEY_IDLE:
          if (wr & sel_key & (wd == `WDR_KEY_FIRST))
            key_reg <= WDR_KEY_HALF;
        WDR_KEY_HALF:
          if (wr)
          begin
            if (sel_key & (wd == `WDR_KEY_SECOND))
            begin
              key_reg    <= WDR_KEY_OPEN;
              ta_cnt_reg <= 4'(`WDR_TA_CYC - 1);
            end
            else
              key_reg <= WDR_KEY_IDLE;
          end
        WDR_KEY_OPEN:
          if (ta_cnt_reg == 4'h0)
            key_reg <= WDR_KEY_IDLE;
          else
            ta_cnt_reg <= ta_cnt_reg - 4'h1;
        default:
          key_reg <= WDR_KEY_IDLE;
      endcase
    end
  end

  // counter, time-out and delayed reset
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_reg     <= WDR_RUN;
      wd_cnt_reg <= 32'h00000000;
      dly_reg    <= 10'h000;
      fire_reg   <= 1'b0;
    end
    else if (restart | pwr_rst | wd_rst_i)
    begin
      st_reg     <= WDR_RUN;
      wd_cnt_reg <= 32'h00000000;
      dly_reg    <= 10'h000;
      fire_reg   <= 1'b0;
    end
    else
    begin
      case (st_reg)
        WDR_RUN:
          if (timeout)
          begin
            wd_cnt_reg <= 32'h00000000;
            dly_reg    <= 10'h000;
            st_reg     <= WDR_WAIT_RST;
          end
          else
            wd_cnt_reg <= wd_cnt_reg + 32'h00000001;
        WDR_WAIT_RST:
          if (dly_reg == `WDR_RST_DELAY - 10'd1)
          begin
            st_reg   <= WDR_FIRE;
            fire_reg <= rsten_reg;
          end
          else
            dly_reg <= dly_reg + 10'd1;
        WDR_FIRE:
          fire_reg <= rsten_reg;
        default:
          st_reg <= WDR_RUN;
      endcase
    end
  end

  // control register; rst_i is the external reset pin
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // external reset: x bits (power-on flag, reset flag, enable) kept,
      // so they are not on the asynchronous branch
      baud2_reg   <= 1'b0;
      irqf_reg    <= 1'b0;
      restart_reg <= 1'b0;
      irqen_reg   <= 1'b0;
      imask_reg   <= '0;
    end
    else
    begin
      restart_reg <= restart;
      if (wr_ctl)
        baud2_reg <= wd[`WDR_B_BAUD2];
      if (wr & sel_ien)
        irqen_reg <= wd[`WDR_B_IRQEN];
      if (wr & sel_msk)
        imask_reg <= wd[`WDR_EV_W-1:0];
      if (timeout)
        irqf_reg <= 1'b1;
      else if (wr_prot)
        irqf_reg <= wd[`WDR_B_IRQF];
    end
  end

  // reset-cause flags, kept through the external reset
  always_ff @(posedge sys_clk_i)
  begin
    if (cause_i.por)
    begin
      por_reg   <= 1'b1;
      rsten_reg <= 1'b0;
    end
    else if (!rst_i && wr_prot)
    begin
      por_reg   <= wd[`WDR_B_POR];
      rsten_reg <= wd[`WDR_B_RSTEN];
    end
    if (pwr_rst)
      rstf_reg <= 1'b0;
    else if (wd_rst_i & rsten_reg)
      rstf_reg <= 1'b1;
    else if (!rst_i && wr_ctl && !wd[`WDR_B_RSTF])
      rstf_reg <= 1'b0;
  end

  // sticky interrupt status, cleared by reading it; set wins
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      istat_reg <= '0;
    else
      istat_reg <= (rd_ist ? '0 : istat_reg) | ev;
  end

endmodule

// ---- test/wdr_watchdog_properties.sv ----
/*
  port assertions for the watchdog block.
  assumes: bound into wdr_watchdog, time-out parameter handed on.
*/
`timescale 1ns/100ps
`include "wdr_regs.svh"
module wdr_watchdog_properties
  import wdr_pkg::*;
#(
  parameter int TIMEOUT_CYC = 64
)
(
  // clock and resets
  input wire logic           sys_clk_i,
  input wire logic           rst_i,
  input wire wdr_rst_cause_t cause_i,
  input wire logic           wd_rst_i,
  // register bus
  input wire logic [9:0]     avs_address_i,
  input wire logic           avs_read_i,
  input wire logic           avs_write_i,
  input wire logic [31:0]    avs_writedata_i,
  input wire logic [31:0]    avs_readdata_o,
  input wire logic           avs_waitrequest_o,
  // events
  input wire logic           wdog_irq_o,
  input wire logic           wdog_reset_o,
  input wire logic           irq_o
);
  logic [31:0] since_rst;
  wire  [7:0]  idx  = avs_address_i[9:2];
  wire         rd_ok = avs_read_i && !avs_waitrequest_o;
  wire         known = idx == `WDR_IDX_WDCTL || idx == `WDR_IDX_TAKEY
                    || idx == `WDR_IDX_IRQEN || idx == `WDR_IDX_ISTAT
                    || idx == `WDR_IDX_IMASK;

  // cycles since the external reset let go, saturating
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      since_rst <= '0;
    else if (since_rst != '1)
      since_rst <= since_rst + 32'h1;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  bus_one_wait_a:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("bus answer late");
  bus_idle_a:
    assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("wait without request");
  ctl_restart_zero_a:
    assert property (rd_ok && idx == `WDR_IDX_WDCTL
      |-> avs_readdata_o[0] == 1'b0 && avs_readdata_o[31:8] == 24'h0)
      else $error("restart bit reads back set");
  irqen_top_a:
    assert property (rd_ok && idx == `WDR_IDX_IRQEN
      |-> avs_readdata_o[7:5] == 3'b111) else $error("enable top bits");
  unmapped_zero_a:
    assert property (rd_ok && !known |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
  ext_rst_clr_a:
    assert property ($fell(rst_i) |-> !wdog_irq_o && !irq_o)
      else $error("interrupt survives reset");
  irq_late_a:
    assert property ($rose(wdog_irq_o) |-> since_rst >= TIMEOUT_CYC - 2)
      else $error("time-out too early");
  rst_late_a:
    assert property ($rose(wdog_reset_o)
      |-> since_rst >= TIMEOUT_CYC + 510) else $error("reset too early");
  rst_hold_a:
    assert property (wdog_reset_o && !wd_rst_i && !avs_write_i
      && cause_i == 3'h0 |=> wdog_reset_o) else $error("reset dropped");
endmodule

bind wdr_watchdog wdr_watchdog_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) props
(
  .sys_clk_i, .rst_i, .cause_i, .wd_rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .wdog_irq_o, .wdog_reset_o, .irq_o
);

// ---- test/wdr_watchdog_tb.sv ----
/*
  self-checking bench for the watchdog block.
  assumes: design and checker compiled before it.
*/
`timescale 1ns/100ps
`include "wdr_regs.svh"
module wdr_watchdog_tb
  import wdr_pkg::*;
;
  localparam int TO = 64;
  logic           sys_clk_i = 1'b0;
  logic           rst_i = 1'b1;
  wdr_rst_cause_t cause_i = 3'h0;
  logic           wd_rst_i = 1'b0;
  logic [9:0]     avs_address_i = 10'h0;
  logic           avs_read_i = 1'b0;
  logic           avs_write_i = 1'b0;
  logic [31:0]    avs_writedata_i = 32'h0;
  logic [31:0]    avs_readdata_o;
  logic           avs_waitrequest_o, wdog_irq_o, wdog_reset_o, irq_o;
  int             miscompares = 0, n_tests = 0, cyc = 0, t0;
  logic [7:0]     d;

  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;

  wdr_watchdog #(.TIMEOUT_CYC(TO)) dut
  (
    .sys_clk_i, .rst_i, .cause_i, .wd_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .wdog_irq_o, .wdog_reset_o, .irq_o
  );

  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, a);
    n_tests++;
    if (a !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, a);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge sys_clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_writedata_i <= {24'h0, v};
    avs_write_i     <= 1'b1;
    @(posedge sys_clk_i iff !avs_waitrequest_o);
    avs_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge sys_clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_read_i    <= 1'b1;
    @(posedge sys_clk_i iff !avs_waitrequest_o);
    d = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
  endtask
  task automatic pulse(input wdr_rst_cause_t c, input logic w);
    @(posedge sys_clk_i);
    cause_i  <= c;
    wd_rst_i <= w;
    @(posedge sys_clk_i);
    cause_i  <= 3'h0;
    wd_rst_i <= 1'b0;
  endtask
  task automatic t_por();
    pulse(3'h4, 1'b0);
    rd(`WDR_IDX_WDCTL); chk("ctl por", 8'h40, d);
  endtask
  task automatic t_protect();
    wr(`WDR_IDX_WDCTL, 8'h00);
    rd(`WDR_IDX_WDCTL); chk("ctl locked", 8'h40, d);
    wr(`WDR_IDX_WDCTL, 8'h80);
    rd(`WDR_IDX_WDCTL); chk("ctl free bit", 8'hC0, d);
    rd(8'h00); chk("unmapped", 8'h00, d);
  endtask
  task automatic t_unlock();
    wr(`WDR_IDX_TAKEY, `WDR_KEY_FIRST);
    wr(`WDR_IDX_TAKEY, `WDR_KEY_SECOND);
    wr(`WDR_IDX_WDCTL, 8'h03);
    t0 = cyc;
    rd(`WDR_IDX_WDCTL); chk("ctl unlocked", 8'h02, d);
  endtask
  task automatic t_timeout();
    repeat (TO + 8) @(posedge sys_clk_i);
    rd(`WDR_IDX_WDCTL); chk("ctl timeout", 8'h0A, d);
    chk("irq off", 8'h00, {7'h0, wdog_irq_o});
    wr(`WDR_IDX_IMASK, 8'h01);
    chk("irq line", 8'h01, {7'h0, irq_o});
    rd(`WDR_IDX_ISTAT); chk("status", 8'h01, d);
    chk("irq cleared", 8'h00, {7'h0, irq_o});
    wr(`WDR_IDX_IRQEN, 8'h10);
    rd(`WDR_IDX_IRQEN); chk("irq enable", 8'hF0, d);
    chk("irq on", 8'h01, {7'h0, wdog_irq_o});
    while (!wdog_reset_o)
      @(posedge sys_clk_i);
    chk("reset delay", 8'h01, {7'h0, cyc - t0 inside {[570:585]}});
  endtask
  task automatic t_wdreset();
    pulse(3'h0, 1'b1);
    // the feedback pulse is taken at the edge pulse returns on
    @(posedge sys_clk_i);
    chk("reset line", 8'h00, {7'h0, wdog_reset_o});
    rd(`WDR_IDX_WDCTL); chk("ctl wd", 8'h06, d & 8'h06);
    rd(`WDR_IDX_ISTAT); chk("status wd", 8'h02, d & 8'h02);
  endtask
  task automatic t_ext();
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(`WDR_IDX_WDCTL); chk("ctl ext", 8'h06, d);
  endtask
  task automatic t_power();
    pulse(3'h1, 1'b0);
    rd(`WDR_IDX_WDCTL); chk("ctl pfail", 8'h02, d);
    pulse(3'h4, 1'b0);
    rd(`WDR_IDX_WDCTL); chk("ctl poweron", 8'h40, d);
    repeat (TO + 600) @(posedge sys_clk_i);
    chk("no reset", 8'h00, {7'h0, wdog_reset_o});
    rd(`WDR_IDX_WDCTL); chk("ctl unarmed", 8'h48, d);
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_por();
    t_protect();
    t_unlock();
    t_timeout();
    t_wdreset();
    t_ext();
    t_power();
    tally_and_finish();
  end
  initial
  begin
    repeat (4000) @(posedge sys_clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule
